// *** hw/flic_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE1 - Six sources; each external input selectable level or edge by own type bit.
// RULE2 - Vectoring clears external flag only in edge mode; level flag follows pin.
// RULE3 - Timer 0/1 overflow sets flag; vectoring clears it automatically.
// RULE4 - Serial request is OR of rx/tx done; hardware never clears them.
// RULE5 - Software writes to every flag act exactly like hardware set/clear.
// RULE6 - Per-source enables plus global gate blocking all service.
// RULE7 - Each source gets one low-register and one high-register priority bit.
// RULE8 - Level equals {high bit, low bit}; 3 highest, 0 lowest.
// RULE9 - Preemption only by strictly higher level; level 3 never preempted.
// RULE10 - Highest level wins; ties by ext0, tmr0, ext1, tmr1, serial, tmr2.
// RULE11 - Flags sampled at the sampling point, polled the next machine cycle.
// RULE12 - Call blocked by equal/higher in progress, non-final cycle, return or reg write.
// RULE13 - After return or enable/priority access, one more instruction before vectoring.
// RULE14 - Blocked requests are not remembered; each poll uses latest samples.
// RULE15 - Acknowledge is hardware long call: push PC, no status save, load vector.
// RULE16 - Vectors 03,0B,13,1B,23,2B hex in polling order.
// RULE17 - Return clears current level in-progress; plain return leaves it set.
// RULE18 - Type 0 low sample requests; type 1 high-then-low samples set flag.
// RULE19 - External source holds levels one machine cycle; edge needs high then low.
// RULE20 - Level-mode source holds request until call, releases before handler ends.
// RULE21 - Pins inverted and latched at sampling point; two-cycle call, three-cycle latency.
// RULE22 - Machine cycle is twelve periods, six in double-speed mode.
module flic_ctrl
  import flic_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              sys_clk,           // 10 MHz core clock
  input  wire logic              rst_n,             // Sync reset, active low
  input  wire logic [ADDR_W-1:0] reg_addr,          // Register address
  input  wire logic [7:0]        reg_wdata,         // Write data
  input  wire logic              reg_wr,            // Write strobe
  input  wire logic              reg_rd,            // Read strobe
  output logic      [7:0]        reg_rdata,         // Read data, cycle after strobe
  input  wire logic [1:0]        ext_request_pin_n, // External pins, active low
  input  wire logic              timer0_rollover,   // Timer 0 rollover pulse
  input  wire logic              timer1_rollover,   // Timer 1 rollover pulse
  input  wire logic              timer2_ovf_set,    // Timer 2 overflow pulse
  input  wire logic              timer2_ext_set,    // Timer 2 external pulse
  input  wire logic              rx_done_set,       // Receive done pulse
  input  wire logic              tx_done_set,       // Transmit done pulse
  input  wire logic              double_spd,        // Six-period machine cycle
  input  wire logic              instr_final_cycle, // Current cycle ends instruction
  input  wire logic              instr_ret_handler, // Instruction is return_from_handler
  input  wire logic              instr_done,        // Instruction completed pulse
  output logic                   hw_long_call,      // Call request to sequencer
  output logic      [15:0]       call_vector,       // Vector address
  output logic                   call_save_status,  // Status word saved (always 0)
  output logic      [3:0]        in_progress        // Active levels
);
  logic [7:0]         int_enable_reg;
  logic [NUM_SRC-1:0] prio_low_bits_reg;
  logic [NUM_SRC-1:0] prio_high_bits_reg;
  logic               ext0_type_select, ext1_type_select;
  logic               ext0_request_flag, ext1_request_flag;
  logic               timer0_overflow_flag, timer1_overflow_flag;
  logic               timer2_overflow_flag, timer2_external_flag;
  logic               rx_done_flag, tx_done_flag;
  logic [1:0]         pin_meta_reg, pin_sync_reg, pin_prev_reg;
  logic [NUM_SRC-1:0] sample_reg;
  logic [NUM_SRC-1:0] poll_reg;
  logic [NUM_SRC-1:0] pend_w;
  logic               samp_dly_reg;
  logic               hold_reg;
  logic               sample_stb, cycle_stb;
  flic_state_t        state_reg;
  logic [2:0]         win_src_reg;
  logic [NUM_SRC-1:0] req_w;
  logic               poll_ok_w;
  logic [2:0]         best_src_w;
  logic [1:0]         best_lvl_w;
  logic               best_ok_w;
  logic               global_int_gate;
  logic               wr_ie, wr_ipl, wr_iph, wr_timer_ctrl_reg, wr_scon, wr_t2;
  logic               ret_w;
  logic [1:0]         cur_lvl_w;

  assign global_int_gate = int_enable_reg[IE_GATE_BIT];
  assign wr_ie   = reg_wr && (reg_addr == ADDR_IE);
  assign wr_ipl  = reg_wr && (reg_addr == ADDR_IPL);
  assign wr_iph  = reg_wr && (reg_addr == ADDR_IPH);
  assign wr_timer_ctrl_reg = reg_wr && (reg_addr == ADDR_TIMER_CTRL_REG);
  assign wr_scon = reg_wr && (reg_addr == ADDR_SCON);
  assign wr_t2   = reg_wr && (reg_addr == ADDR_T2CON);

  function automatic logic [1:0] src_level(input int s, // [RULE8]
                                           input logic [NUM_SRC-1:0] hi,
                                           input logic [NUM_SRC-1:0] lo);
    return {hi[s], lo[s]};
  endfunction : src_level

  function automatic logic [1:0] top_level(input logic [3:0] act);
    logic [1:0] r;
    r = 2'd0;
    for (int i = 0; i < 4; i++) begin
      if (act[i]) r = 2'(i);
    end
    return r;
  endfunction : top_level

  flic_mc_timer u_mc (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .double_spd (double_spd),
    .sample_stb (sample_stb),
    .cycle_stb  (cycle_stb)
  ); // [RULE22]

  // Two stages before any logic sees the pins
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pin_meta_reg <= 2'b11;
      pin_sync_reg <= 2'b11;
    end else begin
      pin_meta_reg <= ext_request_pin_n;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      int_enable_reg     <= IE_RESET;
      prio_low_bits_reg  <= '0;
      prio_high_bits_reg <= '0;
    end else begin
      if (wr_ie)  int_enable_reg     <= reg_wdata; // [RULE6]
      if (wr_ipl) prio_low_bits_reg  <= reg_wdata[NUM_SRC-1:0]; // [RULE7]
      if (wr_iph) prio_high_bits_reg <= reg_wdata[NUM_SRC-1:0]; // [RULE7]
    end
  end

  logic vec_ext0, vec_ext1, vec_t0, vec_t1;
  // Clear only on the call pulse, so a flag set again during the call survives
  assign vec_ext0 = hw_long_call && (win_src_reg == 3'(SRC_EXT0));
  assign vec_ext1 = hw_long_call && (win_src_reg == 3'(SRC_EXT1));
  assign vec_t0   = hw_long_call && (win_src_reg == 3'(SRC_TMR0));
  assign vec_t1   = hw_long_call && (win_src_reg == 3'(SRC_TMR1));

  // Edge sampling once per machine cycle; sets beat clears in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pin_prev_reg         <= 2'b11;
      ext0_type_select     <= 1'b0;
      ext1_type_select     <= 1'b0;
      ext0_request_flag    <= 1'b0;
      ext1_request_flag    <= 1'b0;
      timer0_overflow_flag <= 1'b0;
      timer1_overflow_flag <= 1'b0;
    end else begin
      if (sample_stb) pin_prev_reg <= pin_sync_reg;
      if (wr_timer_ctrl_reg) begin // [RULE5]
        ext0_type_select     <= reg_wdata[TC_EXT0_TYPE]; // [RULE1]
        ext1_type_select     <= reg_wdata[TC_EXT1_TYPE]; // [RULE1]
        ext0_request_flag    <= reg_wdata[TC_EXT0_FLAG];
        ext1_request_flag    <= reg_wdata[TC_EXT1_FLAG];
        timer0_overflow_flag <= reg_wdata[TC_TMR0_FLAG];
        timer1_overflow_flag <= reg_wdata[TC_TMR1_FLAG];
      end else begin
        if (vec_ext0 && ext0_type_select) ext0_request_flag <= 1'b0; // [RULE2]
        if (vec_ext1 && ext1_type_select) ext1_request_flag <= 1'b0; // [RULE2]
        if (vec_t0) timer0_overflow_flag <= 1'b0; // [RULE3]
        if (vec_t1) timer1_overflow_flag <= 1'b0; // [RULE3]
      end
      if (sample_stb) begin // [RULE21]
        if (!ext0_type_select) ext0_request_flag <= ~pin_sync_reg[0]; // [RULE18]
        else if (pin_prev_reg[0] && !pin_sync_reg[0]) ext0_request_flag <= 1'b1; // [RULE18]
        if (!ext1_type_select) ext1_request_flag <= ~pin_sync_reg[1];
        else if (pin_prev_reg[1] && !pin_sync_reg[1]) ext1_request_flag <= 1'b1;
      end
      if (timer0_rollover) timer0_overflow_flag <= 1'b1; // [RULE3]
      if (timer1_rollover) timer1_overflow_flag <= 1'b1;
    end
  end

  // Serial and timer 2 flags are only cleared by software
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rx_done_flag         <= 1'b0;
      tx_done_flag         <= 1'b0;
      timer2_overflow_flag <= 1'b0;
      timer2_external_flag <= 1'b0;
    end else begin
      if (wr_scon) begin // [RULE4] [RULE5]
        rx_done_flag <= reg_wdata[SC_RX_BIT];
        tx_done_flag <= reg_wdata[SC_TX_BIT];
      end
      if (wr_t2) begin
        timer2_overflow_flag <= reg_wdata[T2_OVF_BIT];
        timer2_external_flag <= reg_wdata[T2_EXT_BIT];
      end
      if (rx_done_set)    rx_done_flag         <= 1'b1;
      if (tx_done_set)    tx_done_flag         <= 1'b1;
      if (timer2_ovf_set) timer2_overflow_flag <= 1'b1;
      if (timer2_ext_set) timer2_external_flag <= 1'b1;
    end
  end

  assign req_w[SRC_EXT0] = ext0_request_flag;
  assign req_w[SRC_TMR0] = timer0_overflow_flag;
  assign req_w[SRC_EXT1] = ext1_request_flag;
  assign req_w[SRC_TMR1] = timer1_overflow_flag;
  assign req_w[SRC_SER]  = rx_done_flag | tx_done_flag; // [RULE4]
  assign req_w[SRC_TMR2] = timer2_overflow_flag | timer2_external_flag;

  // External flags settle one clock after the sampling point
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      samp_dly_reg <= 1'b0;
    end else begin
      samp_dly_reg <= sample_stb;
    end
  end

  // Fresh snapshot each cycle, polled in the next one; nothing older survives
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sample_reg <= '0;
      poll_reg   <= '0;
    end else begin
      if (samp_dly_reg) sample_reg <= req_w; // [RULE11] [RULE14]
      // In double speed the snapshot and the cycle end fall together
      if (cycle_stb) poll_reg <= samp_dly_reg ? req_w : sample_reg; // [RULE11]
    end
  end

  // Gates act at poll time so clearing the global bit stops service at once
  assign pend_w = poll_reg & int_enable_reg[NUM_SRC-1:0]
                & {NUM_SRC{global_int_gate}}; // [RULE6]

  // Scan from lowest polling rank up so earlier sources win ties
  always_comb begin
    best_ok_w  = 1'b0;
    best_src_w = 3'd0;
    best_lvl_w = 2'd0;
    for (int s = NUM_SRC - 1; s >= 0; s--) begin
      if (pend_w[s] && (!best_ok_w ||
          src_level(s, prio_high_bits_reg, prio_low_bits_reg) >= best_lvl_w)) begin
        best_ok_w  = 1'b1;
        best_src_w = 3'(s);
        best_lvl_w = src_level(s, prio_high_bits_reg, prio_low_bits_reg); // [RULE10]
      end
    end
  end

  assign cur_lvl_w = top_level(in_progress);
  // One return event per instruction, at the end of its final machine cycle
  assign ret_w     = cycle_stb && instr_final_cycle && instr_ret_handler;

  // A return or a write to enable/priority holds off vectoring for one more instruction
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hold_reg <= 1'b0;
    end else if (ret_w || wr_ie || wr_ipl || wr_iph) begin
      hold_reg <= 1'b1; // [RULE13]
    end else if (instr_done) begin
      hold_reg <= 1'b0;
    end
  end

  assign poll_ok_w = cycle_stb && best_ok_w && (state_reg == FLIC_IDLE)
                   && instr_final_cycle && !instr_ret_handler
                   && !hold_reg && !wr_ie && !wr_ipl && !wr_iph
                   && (in_progress == 4'h0 || best_lvl_w > cur_lvl_w); // [RULE12] [RULE9]

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg   <= FLIC_IDLE;
      win_src_reg <= 3'd0;
    end else begin
      case (state_reg)
        FLIC_IDLE: begin
          if (poll_ok_w) begin
            state_reg   <= FLIC_CALL1;
            win_src_reg <= best_src_w;
          end
        end
        FLIC_CALL1: if (cycle_stb) state_reg <= FLIC_CALL2; // [RULE21]
        FLIC_CALL2: if (cycle_stb) state_reg <= FLIC_IDLE; // [RULE21]
        default:    state_reg <= FLIC_IDLE;
      endcase
    end
  end

  function automatic logic [15:0] vec_of(input logic [2:0] s); // [RULE16]
    case (s)
      3'd0:    return VEC_EXT0;
      3'd1:    return VEC_TMR0;
      3'd2:    return VEC_EXT1;
      3'd3:    return VEC_TMR1;
      3'd4:    return VEC_SER;
      default: return VEC_TMR2;
    endcase
  endfunction : vec_of

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hw_long_call     <= 1'b0;
      call_vector      <= VEC_EXT0;
      call_save_status <= 1'b0;
      in_progress      <= 4'h0;
    end else begin
      hw_long_call     <= poll_ok_w; // [RULE15]
      call_save_status <= 1'b0; // [RULE15]
      if (poll_ok_w) begin
        call_vector <= vec_of(best_src_w);
        in_progress[best_lvl_w] <= 1'b1;
      end else if (ret_w && in_progress != 4'h0) begin
        in_progress[cur_lvl_w] <= 1'b0; // [RULE17]
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_IE:    reg_rdata <= int_enable_reg;
        ADDR_IPL:   reg_rdata <= {2'b00, prio_low_bits_reg};
        ADDR_IPH:   reg_rdata <= {2'b00, prio_high_bits_reg};
        ADDR_TIMER_CTRL_REG:  reg_rdata <= {timer1_overflow_flag, 1'b0, timer0_overflow_flag, 1'b0,
                                  ext1_request_flag, ext1_type_select,
                                  ext0_request_flag, ext0_type_select};
        ADDR_SCON:  reg_rdata <= {6'h00, tx_done_flag, rx_done_flag};
        ADDR_T2CON: reg_rdata <= {timer2_overflow_flag, timer2_external_flag, 6'h00};
        ADDR_STAT:  reg_rdata <= {1'b0, state_reg, in_progress};
        default:    reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  no_eq_preempt_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE9]
    hw_long_call && $past(in_progress) != 4'h0 |->
      call_vector != 16'h0000 && $past(in_progress) != in_progress)
    else $error("Call without raising a new level");
  level3_locked_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE9]
    $past(in_progress[3]) |-> !hw_long_call)
    else $error("Call while level 3 in progress");
  gate_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE6]
    !global_int_gate [*2] |-> !hw_long_call)
    else $error("Call while global gate off");
  call_final_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE12]
    hw_long_call |-> $past(instr_final_cycle) && !$past(instr_ret_handler))
    else $error("Call outside final cycle or on return");
  no_save_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE15]
    !call_save_status)
    else $error("Status saved on call");
  ret_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE17]
    ret_w && !poll_ok_w && in_progress == 4'b0001 |=> in_progress == 4'h0)
    else $error("Return did not clear level");
endmodule : flic_ctrl
`default_nettype wire

// *** hw/flic_mc_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module flic_mc_timer
  import flic_pkg::*;
(
  input  wire logic sys_clk,    // Core clock
  input  wire logic rst_n,      // Sync reset
  input  wire logic double_spd, // Six-period machine cycle
  output logic      sample_stb, // Sampling point pulse
  output logic      cycle_stb   // Last oscillator period of cycle
);
  logic [3:0] phase_reg;
  logic [3:0] last_w;
  logic [3:0] samp_w;

  assign last_w = double_spd ? 4'(OSC_PER_MC_X2 - 1) : 4'(OSC_PER_MC_STD - 1);
  assign samp_w = double_spd ? 4'(SAMPLE_PHASE_X2) : 4'(SAMPLE_PHASE);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      phase_reg <= 4'h0;
    end else if (phase_reg >= last_w) begin
      phase_reg <= 4'h0;
    end else begin
      phase_reg <= phase_reg + 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sample_stb <= 1'b0;
      cycle_stb  <= 1'b0;
    end else begin
      sample_stb <= (phase_reg == samp_w - 4'h1);
      cycle_stb  <= (phase_reg == last_w - 4'h1) || (last_w == 4'h0);
    end
  end
endmodule : flic_mc_timer
`default_nettype wire

// *** hw/flic_pkg.sv ***
package flic_pkg;
  localparam int          NUM_SRC         = 6;
  localparam int          OSC_PER_MC_STD  = 12;
  localparam int          OSC_PER_MC_X2   = 6;
  localparam int          SAMPLE_PHASE    = 9;
  localparam int          SAMPLE_PHASE_X2 = 4;
  localparam int          CALL_CYCLES     = 2;
  localparam logic [7:0]  ADDR_IE         = 8'h00;
  localparam logic [7:0]  ADDR_IPL        = 8'h01;
  localparam logic [7:0]  ADDR_IPH        = 8'h02;
  localparam logic [7:0]  ADDR_TIMER_CTRL_REG       = 8'h03;
  localparam logic [7:0]  ADDR_SCON       = 8'h04;
  localparam logic [7:0]  ADDR_T2CON      = 8'h05;
  localparam logic [7:0]  ADDR_STAT       = 8'h06;
  localparam logic [7:0]  IE_RESET        = 8'h00;
  localparam int          IE_GATE_BIT     = 7;
  localparam int          TC_EXT0_FLAG    = 1;
  localparam int          TC_EXT0_TYPE    = 0;
  localparam int          TC_EXT1_FLAG    = 3;
  localparam int          TC_EXT1_TYPE    = 2;
  localparam int          TC_TMR0_FLAG    = 5;
  localparam int          TC_TMR1_FLAG    = 7;
  localparam int          SC_TX_BIT       = 1;
  localparam int          SC_RX_BIT       = 0;
  localparam int          T2_OVF_BIT      = 7;
  localparam int          T2_EXT_BIT      = 6;
  localparam logic [15:0] VEC_EXT0        = 16'h0003;
  localparam logic [15:0] VEC_TMR0        = 16'h000B;
  localparam logic [15:0] VEC_EXT1        = 16'h0013;
  localparam logic [15:0] VEC_TMR1        = 16'h001B;
  localparam logic [15:0] VEC_SER         = 16'h0023;
  localparam logic [15:0] VEC_TMR2        = 16'h002B;
  localparam int          SRC_EXT0 = 0;
  localparam int          SRC_TMR0 = 1;
  localparam int          SRC_EXT1 = 2;
  localparam int          SRC_TMR1 = 3;
  localparam int          SRC_SER  = 4;
  localparam int          SRC_TMR2 = 5;
  typedef enum logic [2:0] {
    FLIC_IDLE  = 3'b001,
    FLIC_CALL1 = 3'b010,
    FLIC_CALL2 = 3'b100
  } flic_state_t;
endpackage : flic_pkg

// *** tb/flic_cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module flic_cpu_model (
  input  wire logic sys_clk,           // Core clock
  input  wire logic rst_n,             // Sync reset, active low
  input  wire logic double_spd,        // Six-period machine cycle
  input  wire logic hw_long_call,      // Call request from controller
  input  wire logic ret_req,           // Bench asks for a return
  output logic      instr_final_cycle, // Last cycle of instruction
  output logic      instr_ret_handler, // Return instruction running
  output logic      instr_done         // Instruction end pulse
);
  logic [3:0] phase_reg;
  logic [3:0] last_w;
  logic [4:0] call_reg;
  logic       ret_reg;

  // One single-cycle instruction per machine cycle, in step with the divider
  assign last_w = double_spd ? 4'h5 : 4'hB;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) phase_reg <= 4'h0;
    else phase_reg <= (phase_reg >= last_w) ? 4'h0 : phase_reg + 4'h1;
  end
  assign instr_done = (phase_reg == last_w);

  // The call itself occupies two machine cycles with no final cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) call_reg <= 5'h00;
    else if (hw_long_call) call_reg <= double_spd ? 5'h0C : 5'h18;
    else if (call_reg != 5'h00) call_reg <= call_reg - 5'h01;
  end
  assign instr_final_cycle = (call_reg == 5'h00);

  // A return asked for during the call waits until an instruction can end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) ret_reg <= 1'b0;
    else if (ret_req) ret_reg <= 1'b1;
    else if (instr_done && instr_final_cycle) ret_reg <= 1'b0;
  end
  assign instr_ret_handler = ret_reg;
endmodule : flic_cpu_model
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench
  import flic_pkg::*;
;
  logic        sys_clk   = 1'b0;
  logic        rst_n     = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [1:0]  pin_n     = 2'h3;
  logic        dbl       = 1'b0;
  logic [6:0]  ev        = 7'h00;
  logic [7:0]  reg_rdata;
  logic        fin, rett, done, hw_long_call, call_save_status;
  logic [15:0] call_vector;
  logic [3:0]  in_progress;
  logic [15:0] call_q[$];
  int          bad_count = 0;
  int          checks    = 0;

  always #50 sys_clk = ~sys_clk;

  flic_ctrl flic_ctrl_i (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_request_pin_n(pin_n), .timer0_rollover(ev[0]), .timer1_rollover(ev[1]),
    .timer2_ovf_set(ev[2]), .timer2_ext_set(ev[3]), .rx_done_set(ev[4]),
    .tx_done_set(ev[5]), .double_spd(dbl), .instr_final_cycle(fin),
    .instr_ret_handler(rett), .instr_done(done), .hw_long_call(hw_long_call),
    .call_vector(call_vector), .call_save_status(call_save_status),
    .in_progress(in_progress));

  flic_cpu_model flic_cpu_model_i (.sys_clk(sys_clk), .rst_n(rst_n), .double_spd(dbl),
    .hw_long_call(hw_long_call), .ret_req(ev[6]), .instr_final_cycle(fin),
    .instr_ret_handler(rett), .instr_done(done));

  // Calls are logged so a vector taken right after a return is not missed
  always @(posedge sys_clk) if (hw_long_call === 1'b1) call_q.push_back(call_vector);

  task automatic wrap_up;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 chk(name, 16'(exp), 16'(reg_rdata));
  endtask : rd_chk

  // Bits: 0 tmr0, 1 tmr1, 2 tmr2 ovf, 3 tmr2 ext, 4 rx, 5 tx, 6 return
  task automatic pulse(input int k);
    @(posedge sys_clk);
    ev[k] <= 1'b1;
    @(posedge sys_clk);
    ev[k] <= 1'b0;
  endtask : pulse

  task automatic wait_call(input logic [15:0] vec, input logic [3:0] ip);
    int n;
    n = 0;
    while (call_q.size() == 0 && n < 400) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk("call_vector", vec, (call_q.size() != 0) ? call_q.pop_front() : 16'hFFFF);
    chk("in_progress", 16'(ip), 16'(in_progress));
    chk("call_save_status", 16'h0000, 16'(call_save_status));
  endtask : wait_call

  task automatic no_call(input int n);
    tick(n);
    chk("call_count", 16'h0000, 16'(call_q.size()));
    call_q.delete();
  endtask : no_call

  task automatic ret_idle;
    pulse(6);
    tick(40);
    chk("in_progress", 16'h0000, 16'(in_progress));
  endtask : ret_idle

  task automatic t_reset;
    #1 chk("call_vector", VEC_EXT0, call_vector);
    chk("in_progress", 16'h0000, 16'(in_progress));
    rd_chk("ie", ADDR_IE, IE_RESET);
    rd_chk("stat", ADDR_STAT, {1'b0, FLIC_IDLE, 4'h0});
    wr(8'h07, 8'hFF);
    rd_chk("unmapped", 8'h07, 8'h00);
    no_call(30);
  endtask : t_reset

  task automatic t_level;
    wr(ADDR_IE, 8'h81);
    @(posedge sys_clk) pin_n[0] <= 1'b0; // held until the call
    wait_call(VEC_EXT0, 4'h1);
    rd_chk("timer_ctrl_reg", ADDR_TIMER_CTRL_REG, 8'h02);
    no_call(60);
    @(posedge sys_clk) pin_n[0] <= 1'b1; // released before return
    tick(40);
    rd_chk("timer_ctrl_reg", ADDR_TIMER_CTRL_REG, 8'h00);
    ret_idle();
    no_call(40);
  endtask : t_level

  task automatic t_edge;
    wr(ADDR_IE, 8'h84);
    wr(ADDR_TIMER_CTRL_REG, 8'h04);
    tick(30); // pin high for over a machine cycle
    @(posedge sys_clk) pin_n[1] <= 1'b0;
    wait_call(VEC_EXT1, 4'h1);
    rd_chk("timer_ctrl_reg", ADDR_TIMER_CTRL_REG, 8'h04);
    ret_idle();
    no_call(60);
    @(posedge sys_clk) pin_n[1] <= 1'b1;
  endtask : t_edge

  task automatic t_timer0;
    wr(ADDR_IE, 8'h82);
    pulse(0);
    wait_call(VEC_TMR0, 4'h1);
    rd_chk("timer_ctrl_reg", ADDR_TIMER_CTRL_REG, 8'h04);
    ret_idle();
  endtask : t_timer0

  task automatic t_gate;
    wr(ADDR_IE, 8'h02);
    wr(ADDR_TIMER_CTRL_REG, 8'h24);
    no_call(60);
    wr(ADDR_TIMER_CTRL_REG, 8'h04);
    wr(ADDR_IE, 8'h82);
    no_call(60);
    wr(ADDR_TIMER_CTRL_REG, 8'h24);
    wait_call(VEC_TMR0, 4'h1);
    ret_idle();
  endtask : t_gate

  task automatic t_serial;
    wr(ADDR_IE, 8'h90);
    pulse(4);
    wait_call(VEC_SER, 4'h1);
    rd_chk("scon", ADDR_SCON, 8'h01);
    wr(ADDR_SCON, 8'h00);
    ret_idle();
    no_call(60);
  endtask : t_serial

  task automatic t_prio;
    wr(ADDR_IE, 8'h00);
    wr(ADDR_IPL, 8'h20);
    wr(ADDR_IPH, 8'h38);
    rd_chk("ipl", ADDR_IPL, 8'h20);
    rd_chk("iph", ADDR_IPH, 8'h38);
    pulse(0);
    pulse(1);
    pulse(5);
    pulse(2);
    rd_chk("t2con", ADDR_T2CON, 8'h80);
    wr(ADDR_IE, 8'hBA);
    wait_call(VEC_TMR2, 4'h8);
    wr(ADDR_T2CON, 8'h00);
    no_call(60);
    pulse(6);
    wait_call(VEC_TMR1, 4'h4);
    pulse(3);
    wait_call(VEC_TMR2, 4'hC);
    wr(ADDR_T2CON, 8'h00);
    pulse(6);
    no_call(60);
    chk("in_progress", 16'h0004, 16'(in_progress));
    pulse(6);
    wait_call(VEC_SER, 4'h4);
    wr(ADDR_SCON, 8'h00);
    pulse(6);
    wait_call(VEC_TMR0, 4'h1);
    ret_idle();
  endtask : t_prio

  // Mode is changed only under reset so divider and sequencer restart together
  task automatic t_double;
    @(posedge sys_clk);
    rst_n <= 1'b0;
    dbl   <= 1'b1;
    tick(12);
    rst_n <= 1'b1;
    tick(2);
    call_q.delete();
    chk("in_progress", 16'h0000, 16'(in_progress));
    wr(ADDR_IE, 8'h82);
    pulse(0);
    wait_call(VEC_TMR0, 4'h1);
    ret_idle();
  endtask : t_double

  initial begin
    tick(12);
    @(posedge sys_clk) rst_n <= 1'b1;
    tick(1);
    t_reset();
    t_level();
    t_edge();
    t_timer0();
    t_gate();
    t_serial();
    t_prio();
    t_double();
    wrap_up();
  end

  // Scenarios need well under 15000 cycles
  initial begin
    #3000000;
    bad_count++;
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
